// >>> design/shs_defs.svh
// Constants for the servo homing sequencer: APB offsets, fields, resets.
// Assumes inclusion by bare name from the package and design module.
`ifndef SHS_DEFS_SVH
`define SHS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SHS_CFG_OFS 12'h000
`define SHS_SPEED_OFS 12'h004
`define SHS_SHIFT_OFS 12'h008
`define SHS_REVAMT_OFS 12'h00C
`define SHS_STOPPER_OFS 12'h010
`define SHS_STATUS_OFS 12'h014
`define SHS_POS_OFS 12'h018

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define SHS_CFG_STARTDIR_LSB 0
`define SHS_CFG_POSTDIR_BIT 2
`define SHS_CFG_SHIFTREF_LSB 4
`define SHS_CFG_HOMEREF_LSB 8
`define SHS_CFG_EDGE_BIT 12
`define SHS_CFG_CREEPREV_BIT 13
`define SHS_CFG_RANGE_LSB 16
`define SHS_CFG_RST 32'h0000_0010

// ----------------------------------------------------------------
// Setting encodings and reset values
// ----------------------------------------------------------------
`define SHS_DIR_AUTO 2'h2
`define SHS_SREF_LS 3'h0
`define SHS_SREF_Z 3'h1
`define SHS_SREF_STOP 3'h5
`define SHS_HREF_LS 3'h0
`define SHS_HREF_Z 3'h3
`define SHS_SPEED_RST 32'h0032_01F4
`define SHS_SHIFT_RST 32'h0000_03E8
`define SHS_STOPPER_RST 32'h0000_0000

// Brief stop at the switch-release reversal and zero-speed pulse length
`define SHS_PAUSE_NS 40
`define SHS_CLK_NS 4
`define SHS_PAUSE_CYC ((`SHS_PAUSE_NS + `SHS_CLK_NS - 1) / `SHS_CLK_NS)

`endif

// >>> design/shs_pkg.sv
// Types shared by the servo homing sequencer.
// Assumes shs_defs.svh is on the include path.
package shs_pkg;
	`include "shs_defs.svh"

	typedef enum logic [3:0] {
		SHS_IDLE = 4'b0000,
		SHS_FAST = 4'b0001,
		SHS_PAUSE = 4'b0010,
		SHS_CREEP = 4'b0011,
		SHS_SHIFT = 4'b0100,
		SHS_CONTACT = 4'b0101,
		SHS_DONE = 4'b0110,
		SHS_ABORT = 4'b0111,
		SHS_REVERSE = 4'b1000
	} shs_state_t;
endpackage

// >>> design/shs_homing_seq.sv
// Homing sequencer: APB register slave plus homing state machine.
// Assumes all inputs synchronous to i_clock; position from encoder logic.
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.svh"

// Summary of operation
// [R1] Setting 2 picks direction from switch state
// [R2] Auto direction only for switch-based references
// [R3] Setting 2 forces reverse travel to zero
// [R4] Edge select: 0 rising, 1 trailing
// [R5] Request rising edge starts at homing speed, except Z reference at creep speed
// [R6] Switch release: brief stop, then creep
// [R7] First Z after switch: shift, stop, complete
// [R8] Reversal pulses zero-speed and in-position
// [R9] Start inside switch: reverse, creep on release
// [R10] Creep-reverse enable: reverse on switch entry
// [R11] Z reference: creep, shift after Z, complete
// [R12] Z reference overrides shift-reference setting
// [R13] Overtravel at start blocks Z homing
// [R14] Overtravel mid Z homing aborts, stops
// [R15] Stopper: limit torque, time detection interval
// [R16] Zero shift: finish at contact point
// [R17] Nonzero shift: back away, then finish
// [R18] Direction codes: 0 forward, 1 reverse
// [R19] Range 0 keeps home output on
// [R20] Forward increases position, reverse decreases
// [R21] Requests ignored while homing runs
module shs_homing_seq
	import shs_pkg::*;
#(
	parameter int POS_W = 32
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic i_homing_request_input,
	input wire logic i_home_switch,
	input wire logic i_z_phase,
	input wire logic i_overtravel_limit,
	input wire logic i_stopper_contact,
	input wire logic [POS_W-1:0] i_position,
	output logic o_move,
	output logic o_dir_reverse,
	output logic o_creep,
	output logic [15:0] o_speed,
	output logic o_torque_limit_en,
	output logic [15:0] o_torque_limit,
	output logic o_zero_speed,
	output logic o_in_position_flag,
	output logic o_homing_complete,
	output logic o_home_position
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [31:0] cfg_r;
	logic [31:0] speed_r;
	logic [31:0] shift_r;
	logic [31:0] revamt_r;
	logic [31:0] stopper_r;
	logic [POS_W-1:0] home_pos_r;
	logic [1:0] start_direction_setting;
	logic post_reference_direction;
	logic [2:0] shift_reference_select;
	logic [2:0] homing_reference_select;
	logic switch_edge_select;
	logic creep_decel_reverse_enable;
	logic [15:0] home_detect_range;
	logic [15:0] homing_speed_setting;
	logic [15:0] creep_speed_setting;
	logic [31:0] home_shift_amount;
	logic [31:0] reverse_travel_amount;
	logic [15:0] stopper_detect_time;
	logic [15:0] stopper_torque_limit;

	assign start_direction_setting = cfg_r[`SHS_CFG_STARTDIR_LSB +: 2];
	assign post_reference_direction = cfg_r[`SHS_CFG_POSTDIR_BIT];
	assign shift_reference_select = cfg_r[`SHS_CFG_SHIFTREF_LSB +: 3];
	assign homing_reference_select = cfg_r[`SHS_CFG_HOMEREF_LSB +: 3];
	assign switch_edge_select = cfg_r[`SHS_CFG_EDGE_BIT];
	assign creep_decel_reverse_enable = cfg_r[`SHS_CFG_CREEPREV_BIT];
	assign home_detect_range = cfg_r[`SHS_CFG_RANGE_LSB +: 16];
	assign homing_speed_setting = speed_r[15:0];
	assign creep_speed_setting = speed_r[31:16];
	assign home_shift_amount = shift_r;
	assign stopper_detect_time = stopper_r[15:0];
	assign stopper_torque_limit = stopper_r[31:16];
	// Automatic start direction ignores the stored reverse amount
	assign reverse_travel_amount = (start_direction_setting == `SHS_DIR_AUTO)
		? 32'h0000_0000 : revamt_r; // [R3]

	wire wr_en = psel && penable && pwrite;
	wire rd_sel = psel && !pwrite;
	wire hit_cfg = (paddr == `SHS_CFG_OFS);
	wire hit_speed = (paddr == `SHS_SPEED_OFS);
	wire hit_shift = (paddr == `SHS_SHIFT_OFS);
	wire hit_revamt = (paddr == `SHS_REVAMT_OFS);
	wire hit_stopper = (paddr == `SHS_STOPPER_OFS);
	wire hit_status = (paddr == `SHS_STATUS_OFS);
	wire hit_pos = (paddr == `SHS_POS_OFS);
	wire hit_any = hit_cfg | hit_speed | hit_shift | hit_revamt |
		hit_stopper | hit_status | hit_pos;

	shs_state_t state_r;
	shs_state_t state_nxt;
	logic [31:0] status_word;
	logic [31:0] pos_word;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign pos_word = 32'(home_pos_r);
	assign status_word = {16'h0000, 4'h0, state_r, 4'h0,
		o_homing_complete, o_home_position, o_dir_reverse, o_move};
	assign prdata = !rd_sel ? 32'h0000_0000 :
		hit_cfg ? cfg_r :
		hit_speed ? speed_r :
		hit_shift ? shift_r :
		hit_revamt ? reverse_travel_amount :
		hit_stopper ? stopper_r :
		hit_status ? status_word :
		hit_pos ? pos_word : 32'h0000_0000;

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cfg_r <= `SHS_CFG_RST;
			speed_r <= `SHS_SPEED_RST;
			shift_r <= `SHS_SHIFT_RST;
			revamt_r <= 32'h0000_0000;
			stopper_r <= `SHS_STOPPER_RST;
		end
		else if (wr_en)
		begin
			if (hit_cfg)
				cfg_r <= pwdata;
			if (hit_speed)
				speed_r <= pwdata;
			if (hit_shift)
				shift_r <= pwdata;
			if (hit_revamt)
				revamt_r <= pwdata;
			if (hit_stopper)
				stopper_r <= pwdata;
		end
	end

	// ----------------------------------------------------------------
	// Input edges and profile decode
	// ----------------------------------------------------------------
	logic req_d_r;
	logic ls_d_r;
	logic z_d_r;
	wire req_rise = i_homing_request_input && !req_d_r;
	wire ls_rise = i_home_switch && !ls_d_r;
	wire ls_fall = !i_home_switch && ls_d_r;
	wire z_rise = i_z_phase && !z_d_r;
	// Edge relative to homing direction: 0 rising, 1 trailing
	wire ls_sel_edge = switch_edge_select ? ls_fall : ls_rise; // [R4]

	wire z_ref = (homing_reference_select == `SHS_HREF_Z);
	// Z reference overrides the shift-reference choice
	wire stop_ref = !z_ref &&
		(shift_reference_select == `SHS_SREF_STOP); // [R12]
	wire shift_on_z = z_ref ||
		(shift_reference_select == `SHS_SREF_Z); // [R12]
	wire auto_ok = (shift_reference_select == `SHS_SREF_LS) ||
		((shift_reference_select == `SHS_SREF_Z) &&
		(homing_reference_select == `SHS_HREF_LS)); // [R2]
	wire auto_dir = (start_direction_setting == `SHS_DIR_AUTO);
	// 0 forward, 1 reverse; inside switch start opposite to homing dir
	wire start_rev = (auto_dir && auto_ok) ?
		(i_home_switch ? !post_reference_direction
		: post_reference_direction) // [R1]
		: auto_dir ? post_reference_direction
		: start_direction_setting[0]; // [R18]

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic dir_r;
	logic dir_nxt;
	logic found_r;
	logic found_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [7:0] pulse_r;
	logic [7:0] pulse_nxt;
	logic [POS_W-1:0] anchor_r;
	logic [POS_W-1:0] anchor_nxt;
	logic [POS_W-1:0] travel;
	logic done_r;
	logic done_nxt;
	wire [7:0] pause_cyc = 8'(`SHS_PAUSE_CYC);
	wire shift_zero = (home_shift_amount == 32'h0000_0000);
	wire shift_reached = (travel >= POS_W'(home_shift_amount));
	// Forward counts up, reverse counts down
	assign travel = dir_r ? (anchor_r - i_position)
		: (i_position - anchor_r); // [R20]

	always_comb
	begin
		state_nxt = state_r;
		dir_nxt = dir_r;
		found_nxt = found_r;
		cnt_nxt = cnt_r;
		pulse_nxt = (pulse_r != 8'h00) ? pulse_r - 8'h01 : 8'h00;
		anchor_nxt = anchor_r;
		done_nxt = done_r;
		case (state_r)
			SHS_IDLE, SHS_DONE, SHS_ABORT:
			begin
				// Only idle, complete or aborted states take a request
				if (req_rise) // [R21]
				begin
					if (z_ref && i_overtravel_limit) // [R13]
						state_nxt = SHS_ABORT;
					else
					begin
						done_nxt = 1'b0;
						found_nxt = 1'b0;
						dir_nxt = start_rev;
						state_nxt = z_ref ? SHS_CREEP : SHS_FAST; // [R5] [R11]
					end
				end
			end
			SHS_FAST:
			begin
				if (stop_ref && i_stopper_contact)
				begin
					cnt_nxt = 32'(stopper_detect_time); // [R15]
					state_nxt = SHS_CONTACT;
				end
				else if (!stop_ref && dir_r != post_reference_direction &&
					ls_fall)
				begin
					// Leaving switch against homing dir: stop, turn round
					cnt_nxt = {24'h000000, pause_cyc}; // [R6] [R9]
					state_nxt = SHS_REVERSE;
				end
				else if (!stop_ref && dir_r == post_reference_direction &&
					ls_rise && creep_decel_reverse_enable)
				begin
					dir_nxt = !dir_r; // [R10]
					pulse_nxt = pause_cyc; // [R8]
					state_nxt = SHS_FAST;
				end
				else if (!stop_ref && dir_r == post_reference_direction &&
					ls_sel_edge)
				begin
					found_nxt = 1'b1;
					state_nxt = SHS_CREEP;
				end
			end
			SHS_REVERSE:
			begin
				pulse_nxt = pause_cyc; // [R8]
				if (cnt_r == 32'h0000_0000)
				begin
					dir_nxt = post_reference_direction; // [R6]
					state_nxt = SHS_CREEP;
				end
				else
					cnt_nxt = cnt_r - 32'h0000_0001;
			end
			SHS_CREEP:
			begin
				if (ls_sel_edge || ls_rise)
					found_nxt = 1'b1;
				if (z_ref && i_overtravel_limit) // [R14]
					state_nxt = SHS_ABORT;
				else if ((z_ref || found_r) &&
					(shift_on_z ? z_rise : 1'b1))
				begin
					anchor_nxt = i_position; // [R7] [R11]
					state_nxt = SHS_SHIFT;
				end
			end
			SHS_SHIFT:
			begin
				if (z_ref && i_overtravel_limit) // [R14]
					state_nxt = SHS_ABORT;
				else if (shift_reached) // [R7] [R17]
				begin
					done_nxt = 1'b1;
					state_nxt = SHS_DONE;
				end
			end
			SHS_CONTACT:
			begin
				if (cnt_r != 32'h0000_0000)
					cnt_nxt = cnt_r - 32'h0000_0001; // [R15]
				else if (shift_zero)
				begin
					done_nxt = 1'b1; // [R16]
					state_nxt = SHS_DONE;
				end
				else
				begin
					// Back away from the stopper
					dir_nxt = !dir_r; // [R17]
					anchor_nxt = i_position;
					state_nxt = SHS_SHIFT;
				end
			end
			default:
				state_nxt = SHS_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= SHS_IDLE;
			dir_r <= 1'b0;
			found_r <= 1'b0;
			cnt_r <= 32'h0000_0000;
			pulse_r <= 8'h00;
			anchor_r <= '0;
			done_r <= 1'b0;
			home_pos_r <= '0;
			req_d_r <= 1'b0;
			ls_d_r <= 1'b0;
			z_d_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			dir_r <= dir_nxt;
			found_r <= found_nxt;
			cnt_r <= cnt_nxt;
			pulse_r <= pulse_nxt;
			anchor_r <= anchor_nxt;
			done_r <= done_nxt;
			req_d_r <= i_homing_request_input;
			ls_d_r <= i_home_switch;
			z_d_r <= i_z_phase;
			if (done_nxt && !done_r)
				home_pos_r <= i_position; // [R7]
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	wire moving = (state_r == SHS_FAST) || (state_r == SHS_CREEP) ||
		(state_r == SHS_SHIFT);
	wire slow = (state_r == SHS_CREEP) || (state_r == SHS_SHIFT) ||
		found_r;
	wire near_home = ((i_position - home_pos_r) <= POS_W'(home_detect_range))
		|| ((home_pos_r - i_position) <= POS_W'(home_detect_range));

	assign o_move = moving;
	assign o_dir_reverse = dir_r; // [R18]
	assign o_creep = moving && slow;
	assign o_speed = !moving ? 16'h0000 :
		slow ? creep_speed_setting : homing_speed_setting; // [R5]
	assign o_torque_limit_en = (state_r == SHS_CONTACT); // [R15]
	assign o_torque_limit = o_torque_limit_en ? stopper_torque_limit
		: 16'h0000;
	assign o_zero_speed = !moving || (pulse_r != 8'h00); // [R8]
	assign o_in_position_flag = done_r || (pulse_r != 8'h00); // [R8]
	assign o_homing_complete = done_r;
	// Range zero keeps the output on after completion
	assign o_home_position = done_r &&
		((home_detect_range == 16'h0000) || near_home); // [R19]

endmodule
`default_nettype wire

// >>> bench/shs_homing_seq_assertions.sv
// Port checker for the homing sequencer.
// Assumes detect range stays 0 and overtravel only in Z homing.
`timescale 1ns/1ps
`default_nettype none
module shs_checker
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic i_homing_request_input,
	input wire logic i_overtravel_limit,
	input wire logic i_stopper_contact,
	input wire logic o_move,
	input wire logic [15:0] o_speed,
	input wire logic o_torque_limit_en,
	input wire logic o_zero_speed,
	input wire logic o_in_position_flag,
	input wire logic o_homing_complete,
	input wire logic o_home_position
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// ----
	// Homing start sequences and port checks
	// ----
	sequence s_req_edge;
		!i_homing_request_input ##1 i_homing_request_input;
	endsequence
	sequence s_started;
		o_move && o_speed != 16'h0000;
	endsequence
	AST_APB_READY: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	AST_APB_UNMAPPED: assert property (psel && penable && paddr == 12'h100
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	AST_START: assert property (
		s_req_edge ##0 (!o_move && !i_overtravel_limit &&
		!o_torque_limit_en && (o_homing_complete || !o_in_position_flag))
		|=> s_started)
		else $error("request edge did not start motion");
	AST_STOP_ZERO: assert property (!o_move |->
		o_zero_speed && o_speed == 16'h0000)
		else $error("stopped without zero speed");
	AST_DONE_STILL: assert property (
		o_homing_complete |-> !o_move && o_in_position_flag)
		else $error("complete while moving");
	AST_HOME_OUT: assert property (
		o_homing_complete |-> o_home_position)
		else $error("home output dropped after completion");
	AST_OT_HALT: assert property (
		i_overtravel_limit && o_move |-> ##[1:4] !o_move)
		else $error("overtravel did not stop motion");
	AST_TORQUE_CONTACT: assert property (
		$rose(o_torque_limit_en) |-> i_stopper_contact)
		else $error("torque limit without contact");
endmodule
bind shs_homing_seq shs_checker shs_checker_inst (.i_clock, .i_rst_n,
	.psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.i_homing_request_input, .i_overtravel_limit, .i_stopper_contact,
	.o_move, .o_speed, .o_torque_limit_en, .o_zero_speed,
	.o_in_position_flag, .o_homing_complete, .o_home_position);
`default_nettype wire

// >>> bench/shs_far_side.sv
// Far side model: encoder count, home switch, Z pulses, stopper.
// Assumes one count per clock of commanded motion.
`timescale 1ns/1ps
`default_nettype none
module shs_far_side
#(
	parameter int SW_LO = 100,
	parameter int SW_HI = 200,
	parameter int STOP_POS = 300
)
(
	input wire logic i_clock,
	input wire logic i_load,
	input wire logic [31:0] i_load_pos,
	input wire logic i_move,
	input wire logic i_dir_reverse,
	input wire logic [15:0] i_speed,
	output logic [31:0] o_position,
	output logic o_home_switch,
	output logic o_z_phase,
	output logic o_stopper_contact
);
	logic blocked;
	assign o_home_switch = $signed(o_position) >= SW_LO
		&& $signed(o_position) <= SW_HI;
	assign o_z_phase = o_position[5:0] == 6'h00;
	assign o_stopper_contact = $signed(o_position) >= STOP_POS;
	// Stopper holds the axis against forward motion
	assign blocked = o_stopper_contact && !i_dir_reverse;
	always_ff @(posedge i_clock)
	begin
		if (i_load)
			o_position <= i_load_pos;
		else if (i_move && i_speed != 16'h0000 && !blocked)
			o_position <= i_dir_reverse ? o_position - 32'h0000_0001
				: o_position + 32'h0000_0001;
	end
endmodule
`default_nettype wire

// >>> bench/shs_homing_seq_bench.sv
// Self-checking bench for the homing sequencer.
// Assumes checker and far side model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.svh"
module shs_homing_seq_bench;
	logic i_clock, i_rst_n, psel, penable, pwrite, pready, pslverr, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, i_position, load_pos, q;
	logic i_homing_request_input, i_home_switch, i_z_phase, load;
	logic i_overtravel_limit, i_stopper_contact, o_move, o_dir_reverse;
	logic o_creep, o_torque_limit_en, o_zero_speed, o_in_position_flag;
	logic o_homing_complete, o_home_position;
	logic [15:0] o_speed, o_torque_limit;
	int error_cnt = 0;
	int comparisons = 0;
	shs_homing_seq shs_homing_seq_inst (.i_clock, .i_rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.i_homing_request_input, .i_home_switch, .i_z_phase,
		.i_overtravel_limit, .i_stopper_contact, .i_position, .o_move,
		.o_dir_reverse, .o_creep, .o_speed, .o_torque_limit_en,
		.o_torque_limit, .o_zero_speed, .o_in_position_flag,
		.o_homing_complete, .o_home_position);
	shs_far_side shs_far_side_inst (.i_clock, .i_load(load),
		.i_load_pos(load_pos), .i_move(o_move),
		.i_dir_reverse(o_dir_reverse), .i_speed(o_speed),
		.o_position(i_position), .o_home_switch(i_home_switch),
		.o_z_phase(i_z_phase), .o_stopper_contact(i_stopper_contact));
	initial
	begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		chk(pready, 1'h1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	task automatic restart(input logic [31:0] p);
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		load <= 1'b1;
		load_pos <= p;
		i_homing_request_input <= 1'b0;
		i_overtravel_limit <= 1'b0;
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		load <= 1'b0;
	endtask
	task automatic setup(input logic [31:0] c, input logic [31:0] p);
		restart(p);
		apb(1'b1, `SHS_CFG_OFS, c, q);
		apb(1'b1, `SHS_SHIFT_OFS, 32'h0000_0014, q);
		apb(1'b1, `SHS_STOPPER_OFS, 32'h0055_0008, q);
	endtask
	task automatic go;
		@(posedge i_clock);
		i_homing_request_input <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_homing_request_input <= 1'b0;
		tick(1);
	endtask
	task automatic wait_done(output int n);
		n = 0;
		while (o_homing_complete !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		rd_chk(`SHS_CFG_OFS, `SHS_CFG_RST);
		rd_chk(`SHS_SPEED_OFS, `SHS_SPEED_RST);
		rd_chk(`SHS_SHIFT_OFS, `SHS_SHIFT_RST);
		rd_chk(`SHS_STOPPER_OFS, `SHS_STOPPER_RST);
		apb(1'b1, `SHS_REVAMT_OFS, 32'h0000_0005, q);
		rd_chk(`SHS_REVAMT_OFS, 32'h0000_0005);
		apb(1'b1, `SHS_CFG_OFS, 32'h0000_0012, q);
		rd_chk(`SHS_REVAMT_OFS, 32'h0000_0000);
		rd_chk(12'h100, 32'h0000_0000);
		chk(perr, 1'h1);
		$display("t_regs done");
	endtask
	task automatic t_zref;
		int n;
		setup(32'h0000_0350, 32'h0000_000A);
		go;
		chk(o_dir_reverse, 1'h0);
		chk(o_creep, 1'h1);
		wait_done(n);
		chk(o_homing_complete, 1'h1);
		chk(i_position >= 84 && i_position <= 86, 1'h1);
		$display("t_zref done");
	endtask
	task automatic t_ot;
		setup(32'h0000_0300, 32'h0000_000A);
		i_overtravel_limit <= 1'b1;
		go;
		chk(o_move, 1'h0);
		setup(32'h0000_0301, 32'h0000_0028);
		go;
		chk(o_dir_reverse, 1'h1);
		repeat (8) @(posedge i_clock);
		i_overtravel_limit <= 1'b1;
		tick(6);
		chk(o_move, 1'h0);
		chk(o_homing_complete, 1'h0);
		$display("t_ot done");
	endtask
	task automatic t_ls(input logic [31:0] p, input logic d);
		int n;
		setup(32'h0000_2012, p);
		go;
		chk(o_dir_reverse, d);
		chk(o_creep, 1'h0);
		wait_done(n);
		chk(o_homing_complete, 1'h1);
		chk(o_dir_reverse, 1'h0);
		$display("t_ls done");
	endtask
	task automatic t_stop(input logic [31:0] s, input logic [31:0] e);
		int n;
		setup(32'h0000_0050, 32'h0000_00FA);
		apb(1'b1, `SHS_SHIFT_OFS, s, q);
		go;
		n = 0;
		while (o_torque_limit_en !== 1'b1 && n < 200)
		begin
			tick(1);
			n++;
		end
		chk(o_torque_limit, 16'h0055);
		n = 0;
		while (o_torque_limit_en === 1'b1 && n < 200)
		begin
			tick(1);
			n++;
		end
		chk(n >= 8 && n <= 9, 1'h1);
		wait_done(n);
		chk(o_homing_complete, 1'h1);
		rd_chk(`SHS_POS_OFS, e);
		if (s == 32'h0000_0000)
			chk(i_position, 32'h0000_012C);
		else
			chk(o_dir_reverse, 1'h1);
		$display("t_stop done");
	endtask
	initial
	begin
		i_rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		i_homing_request_input = 1'b0;
		i_overtravel_limit = 1'b0;
		load = 1'b1;
		load_pos = 32'h0000_0000;
		restart(32'h0000_0000);
		t_regs;
		t_zref;
		t_ot;
		t_ls(32'h0000_0014, 1'b0);
		t_ls(32'h0000_0096, 1'b1);
		t_stop(32'h0000_0000, 32'h0000_012C);
		t_stop(32'h0000_0014, 32'h0000_0118);
		wrap_up;
	end
	initial
	begin
		#40000;
		error_cnt++;
		wrap_up;
	end
endmodule
`default_nettype wire
